//--- port_latches.sv
// two-port output latch block with direction, readback and shared reset pin over Avalon-MM
//
// Summary of operation
// - any reset loads first port latch with FFh
// - any reset loads second port latch with 7Fh
// - eight latch bits drive first port outputs
// - seven latch bits drive second port likewise
// - input pin latch bit controls weak pull-up
// - one enables pull-up, zero leaves pin floating
// - writes update latch, reads return stored latch
// - direction changes never alter latch contents
// - second port latch bit 7 reads zero
// - reset input stays active unless disable set
// - driving shared pin low causes device reset
// - readback register returns sensed pin levels
`timescale 1ns/1ps
`default_nettype none
module port_latches (
   input wire logic mclk_i,                         // core clock, 100 MHz
   input wire logic rst_i,                          // async reset, active high
   input wire logic [7:0] avs_address_i,            // byte address
   input wire logic avs_read_i,                     // read request
   input wire logic avs_write_i,                    // write request
   input wire logic [31:0] avs_writedata_i,         // write data
   input wire logic [3:0] avs_byteenable_i,         // byte lanes
   output logic [31:0] avs_readdata_o,              // read data
   output logic avs_waitrequest_o,                  // high while request not done
   input wire logic [7:0] p0_pin_i,                 // sensed first port pins
   input wire logic [6:0] p1_pin_i,                 // sensed second port pins
   output logic [7:0] p0_out_o,                     // first port drive level
   output logic [7:0] p0_oe_o,                      // first port drive enable
   output logic [7:0] p0_pullup_o,                  // first port pull-up enable
   output logic [6:0] p1_out_o,                     // second port drive level
   output logic [6:0] p1_oe_o,                      // second port drive enable
   output logic [6:0] p1_pullup_o,                  // second port pull-up enable
   output logic reset_request_o                     // device reset from shared pin
);

   ////////////////////////////////////////////////////////////////////////////
   // storage
   logic [7:0] port0_output_latch;
   logic [6:0] port1_output_latch;
   logic [7:0] port0_dir;
   logic [6:0] port1_dir;
   logic reset_pin_disable;
   port_pkg::bus_state_t bus_state;
   logic [31:0] next_readdata;
   logic take;
   logic commit;
   logic lane0;

   // a request is taken while waitrequest is high and committed at the edge it is low
   assign take = (avs_read_i | avs_write_i) & avs_waitrequest_o;
   assign commit = avs_write_i & ~avs_waitrequest_o;
   assign lane0 = avs_byteenable_i[0];

   ////////////////////////////////////////////////////////////////////////////
   // bus handshake: one wait cycle, then waitrequest low for exactly one edge
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         bus_state <= port_pkg::BUS_IDLE;
         avs_waitrequest_o <= 1'b1;
      end
      else
      begin
         case (bus_state)
            port_pkg::BUS_IDLE:
            begin
               if (take)
               begin
                  bus_state <= port_pkg::BUS_ACK;
                  avs_waitrequest_o <= 1'b0;
               end
            end
            port_pkg::BUS_ACK:
            begin
               bus_state <= port_pkg::BUS_IDLE;
               avs_waitrequest_o <= 1'b1;
            end
            default:
            begin
               bus_state <= port_pkg::BUS_IDLE;
               avs_waitrequest_o <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux; unmapped addresses read as zero
   always_comb
   begin
      next_readdata = 32'h00000000;
      case (avs_address_i)
         port_pkg::P0_LATCH_ADDR: next_readdata[7:0] = port0_output_latch;
         port_pkg::P1_LATCH_ADDR: next_readdata[6:0] = port1_output_latch;
         port_pkg::P0_READBACK_ADDR: next_readdata[7:0] = p0_pin_i;
         port_pkg::P1_READBACK_ADDR: next_readdata[6:0] = p1_pin_i;
         port_pkg::P0_DIR_ADDR: next_readdata[7:0] = port0_dir;
         port_pkg::P1_DIR_ADDR: next_readdata[6:0] = port1_dir;
         port_pkg::RST_CTRL_ADDR: next_readdata[port_pkg::RST_DISABLE_BIT] = reset_pin_disable;
         default: next_readdata = 32'h00000000;
      endcase
   end

   // read data is captured when the request is taken so it stands at the commit edge
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         avs_readdata_o <= 32'h00000000;
      else if (take && avs_read_i)
         avs_readdata_o <= next_readdata;
   end

   ////////////////////////////////////////////////////////////////////////////
   // output latches; only their own address touches them, so direction writes cannot
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         port0_output_latch <= port_pkg::P0_LATCH_RESET;
         port1_output_latch <= port_pkg::P1_LATCH_RESET;
      end
      else if (commit && lane0)
      begin
         if (avs_address_i == port_pkg::P0_LATCH_ADDR)
            port0_output_latch <= avs_writedata_i[7:0];
         if (avs_address_i == port_pkg::P1_LATCH_ADDR)
            port1_output_latch <= avs_writedata_i[6:0];
      end
   end

   // direction and reset-pin control
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         port0_dir <= port_pkg::P0_DIR_RESET;
         port1_dir <= port_pkg::P1_DIR_RESET;
         reset_pin_disable <= port_pkg::RST_DISABLE_RESET;
      end
      else if (commit && lane0)
      begin
         if (avs_address_i == port_pkg::P0_DIR_ADDR)
            port0_dir <= avs_writedata_i[7:0];
         if (avs_address_i == port_pkg::P1_DIR_ADDR)
            port1_dir <= avs_writedata_i[6:0];
         if (avs_address_i == port_pkg::RST_CTRL_ADDR)
            reset_pin_disable <= avs_writedata_i[port_pkg::RST_DISABLE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared reset pin: the sensed level is used, so an internal drive low and an
   // external pull low both reset; the reset controller must not feed rst_i back
   // combinationally, this output is a registered request
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         reset_request_o <= 1'b0;
      else
         reset_request_o <= ~reset_pin_disable & ~p1_pin_i[port_pkg::SHARED_RESET_PIN];
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin cells
   pin_driver #(.WIDTH(port_pkg::P0_WIDTH)) u_p0 (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .latch_i(port0_output_latch),
      .dir_i(port0_dir),
      .out_o(p0_out_o),
      .oe_o(p0_oe_o),
      .pullup_o(p0_pullup_o)
   );

   pin_driver #(.WIDTH(port_pkg::P1_WIDTH)) u_p1 (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .latch_i(port1_output_latch),
      .dir_i(port1_dir),
      .out_o(p1_out_o),
      .oe_o(p1_oe_o),
      .pullup_o(p1_pullup_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   property p_p0_reset;
      $past(rst_i) |-> (port0_output_latch == port_pkg::P0_LATCH_RESET)
         && (p0_pullup_o == port_pkg::P0_LATCH_RESET);
   endproperty
   a_p0_reset: assert property (p_p0_reset) else $error("first port latch not FFh after reset");

   property p_p1_reset;
      $past(rst_i) |-> (port1_output_latch == port_pkg::P1_LATCH_RESET);
   endproperty
   a_p1_reset: assert property (p_p1_reset) else $error("second port latch not 7Fh after reset");

   property p_p0_write;
      (commit && lane0 && avs_address_i == port_pkg::P0_LATCH_ADDR)
         |=> ##1 (p0_out_o == $past(avs_writedata_i[7:0], 2));
   endproperty
   a_p0_write: assert property (p_p0_write) else $error("first port write not driven to pins");

   property p_p1_write;
      (commit && lane0 && avs_address_i == port_pkg::P1_LATCH_ADDR)
         |=> (port1_output_latch == $past(avs_writedata_i[6:0]));
   endproperty
   a_p1_write: assert property (p_p1_write) else $error("second port latch write lost");

   property p_read_latch;
      (take && avs_read_i && avs_address_i == port_pkg::P0_LATCH_ADDR)
         |=> !avs_waitrequest_o && (avs_readdata_o == {24'h000000, $past(port0_output_latch)});
   endproperty
   a_read_latch: assert property (p_read_latch) else $error("latch read does not return stored value");

   property p_dir_keeps;
      (commit && (avs_address_i == port_pkg::P0_DIR_ADDR || avs_address_i == port_pkg::P1_DIR_ADDR))
         |=> $stable(port0_output_latch) && $stable(port1_output_latch);
   endproperty
   a_dir_keeps: assert property (p_dir_keeps) else $error("direction write changed a latch");

   property p_bit7_zero;
      (take && avs_read_i && avs_address_i == port_pkg::P1_LATCH_ADDR) |=> (avs_readdata_o[31:7] == 25'h0);
   endproperty
   a_bit7_zero: assert property (p_bit7_zero) else $error("second port latch bit 7 not zero");

   property p_rst_pin;
      (!reset_pin_disable && !p1_pin_i[port_pkg::SHARED_RESET_PIN]) |=> reset_request_o;
   endproperty
   a_rst_pin: assert property (p_rst_pin) else $error("low shared pin did not request reset");

   property p_rst_disabled;
      reset_pin_disable |=> !reset_request_o;
   endproperty
   a_rst_disabled: assert property (p_rst_disabled) else $error("reset requested while disabled");

   property p_readback;
      (take && avs_read_i && avs_address_i == port_pkg::P0_READBACK_ADDR)
         |=> (avs_readdata_o[7:0] == $past(p0_pin_i));
   endproperty
   a_readback: assert property (p_readback) else $error("readback not the sensed pin level");

   property p_handshake;
      take |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
   endproperty
   a_handshake: assert property (p_handshake) else $error("waitrequest sequence broken");

   // an idle slave keeps waitrequest high, so no request completes without being taken
   property p_wait_idle;
      (bus_state == port_pkg::BUS_IDLE && !take)
         |=> avs_waitrequest_o;
   endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low without a taken request");

   property p_p1_read_latch;
      (take && avs_read_i && avs_address_i == port_pkg::P1_LATCH_ADDR)
         |=> (avs_readdata_o[6:0] == $past(port1_output_latch));
   endproperty
   a_p1_read_latch: assert property (p_p1_read_latch) else $error("second port latch read wrong");

   property p_p1_readback;
      (take && avs_read_i && avs_address_i == port_pkg::P1_READBACK_ADDR)
         |=> (avs_readdata_o == {25'h0, $past(p1_pin_i)});
   endproperty
   a_p1_readback: assert property (p_p1_readback) else $error("second port readback not the pin level");

   // latches move only at a committed write, never on the take edge or while idle
   property p_latch_only_on_commit;
      !commit |=> $stable(port0_output_latch) && $stable(port1_output_latch);
   endproperty
   a_latch_only_on_commit: assert property (p_latch_only_on_commit) else $error("latch changed without a write");

   // a write without the low byte lane is answered but must leave every register alone
   property p_lane_refused;
      (commit && !lane0)
         |=> $stable(port0_output_latch) && $stable(port1_output_latch) && $stable(port0_dir)
            && $stable(port1_dir) && $stable(reset_pin_disable);
   endproperty
   a_lane_refused: assert property (p_lane_refused) else $error("write without low lane changed a register");

   property p_unmapped_read;
      (take && avs_read_i && avs_address_i > port_pkg::RST_CTRL_ADDR)
         |=> (avs_readdata_o == 32'h00000000);
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped address did not read zero");

   // direction write reaches the drive enables two edges after commit
   property p_p1_dir_write;
      (commit && lane0 && avs_address_i == port_pkg::P1_DIR_ADDR)
         |=> ##1 (p1_oe_o == $past(avs_writedata_i[6:0], 2));
   endproperty
   a_p1_dir_write: assert property (p_p1_dir_write) else $error("second port direction not applied");

   property p_rst_ctrl_write;
      (commit && lane0 && avs_address_i == port_pkg::RST_CTRL_ADDR)
         |=> (reset_pin_disable == $past(avs_writedata_i[port_pkg::RST_DISABLE_BIT]));
   endproperty
   a_rst_ctrl_write: assert property (p_rst_ctrl_write) else $error("reset pin disable write lost");

   c_write_p0: cover property (commit && avs_address_i == port_pkg::P0_LATCH_ADDR);
   c_read_p1: cover property (take && avs_read_i && avs_address_i == port_pkg::P1_LATCH_ADDR);
   c_pin_reset: cover property (reset_request_o);
   c_output_low: cover property (p1_oe_o[6] && !p1_out_o[6]);

endmodule : port_latches
`default_nettype wire

//--- port_pkg.sv
// package: register map, reset values and widths for the port output latch block
package port_pkg;
   // port widths
   localparam int P0_WIDTH = 8;
   localparam int P1_WIDTH = 7;
   localparam int ADDR_WIDTH = 8;
   localparam int DATA_WIDTH = 32;

   // printed register indices; byte address is four times the index
   localparam logic [7:0] P0_LATCH_IDX = 8'h00;
   localparam logic [7:0] P1_LATCH_IDX = 8'h01;
   localparam logic [7:0] P0_READBACK_IDX = 8'h02;
   localparam logic [7:0] P1_READBACK_IDX = 8'h03;
   localparam logic [7:0] P0_DIR_IDX = 8'h04;
   localparam logic [7:0] P1_DIR_IDX = 8'h05;
   localparam logic [7:0] RST_CTRL_IDX = 8'h06;

   localparam logic [7:0] P0_LATCH_ADDR = 8'(P0_LATCH_IDX * 4);
   localparam logic [7:0] P1_LATCH_ADDR = 8'(P1_LATCH_IDX * 4);
   localparam logic [7:0] P0_READBACK_ADDR = 8'(P0_READBACK_IDX * 4);
   localparam logic [7:0] P1_READBACK_ADDR = 8'(P1_READBACK_IDX * 4);
   localparam logic [7:0] P0_DIR_ADDR = 8'(P0_DIR_IDX * 4);
   localparam logic [7:0] P1_DIR_ADDR = 8'(P1_DIR_IDX * 4);
   localparam logic [7:0] RST_CTRL_ADDR = 8'(RST_CTRL_IDX * 4);

   // reset values
   localparam logic [7:0] P0_LATCH_RESET = 8'hFF;
   localparam logic [6:0] P1_LATCH_RESET = 7'h7F;
   localparam logic [7:0] P0_DIR_RESET = 8'h00;
   localparam logic [6:0] P1_DIR_RESET = 7'h00;
   localparam logic RST_DISABLE_RESET = 1'b0;

   // field positions
   localparam int RST_DISABLE_BIT = 0;
   localparam int SHARED_RESET_PIN = 6;

   // bus handshake states, gray along idle -> ack -> idle
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } bus_state_t;
endpackage : port_pkg

//--- pin_driver.sv
// per-pin drive, enable and weak pull-up control for one port
`timescale 1ns/1ps
`default_nettype none
module pin_driver #(
   parameter int WIDTH = 8
) (
   input wire logic mclk_i,                 // core clock
   input wire logic rst_i,                  // async reset, active high
   input wire logic [WIDTH-1:0] latch_i,    // output latch contents
   input wire logic [WIDTH-1:0] dir_i,      // 1 = output
   output logic [WIDTH-1:0] out_o,          // level driven on pin
   output logic [WIDTH-1:0] oe_o,           // pin drive enable
   output logic [WIDTH-1:0] pullup_o        // weak pull-up enable
);

   ////////////////////////////////////////////////////////////////////////////
   // one registered cell per pin; reset leaves every pin an input with pull-up
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_pin
         always_ff @(posedge mclk_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               out_o[g] <= 1'b1;
               oe_o[g] <= 1'b0;
               pullup_o[g] <= 1'b1;
            end
            else
            begin
               out_o[g] <= latch_i[g];
               oe_o[g] <= dir_i[g];
               pullup_o[g] <= ~dir_i[g] & latch_i[g];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // checks on the pin cells
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   property p_drive;
      ##1 (oe_o == $past(dir_i)) && (out_o == $past(latch_i));
   endproperty
   a_drive: assert property (p_drive) else $error("pin drive does not follow direction and latch");

   property p_pullup_on;
      ##1 (pullup_o == ($past(latch_i) & ~$past(dir_i)));
   endproperty
   a_pullup_on: assert property (p_pullup_on) else $error("pull-up not set by latch on input pins");

   property p_input_quiet;
      (dir_i == '0) |=> (oe_o == '0);
   endproperty
   a_input_quiet: assert property (p_input_quiet) else $error("input pin is being driven");

endmodule : pin_driver
`default_nettype wire

//--- pin_board.sv
// board model: resolves each port pin from block drive, board drive and pull-up
`timescale 1ns/1ps
`default_nettype none
module pin_board (
   input wire logic mclk_i,            // core clock
   input wire logic [14:0] out_i,      // block drive level, second port on top
   input wire logic [14:0] oe_i,       // block drive enable
   input wire logic [14:0] pullup_i,   // weak pull-up enable
   input wire logic [14:0] ext_en_i,   // board drives the pin
   input wire logic [14:0] ext_i,      // board drive level
   output logic [14:0] pin_o           // resolved pin level
);
   logic [14:0] drift = 15'h5555;
   ///////////////////////////////////////////////////////////////////////////
   // a floating pin wanders every cycle, so nothing may rely on its level
   always @(posedge mclk_i)
      drift <= ~drift;
   // block driver first, then the board, then the pull-up, else floating
   always_comb
      for (int i = 0; i < 15; i++)
         pin_o[i] = oe_i[i] ? out_i[i] : ext_en_i[i] ? ext_i[i] : pullup_i[i] ? 1'b1 : drift[i];
endmodule : pin_board
`default_nettype wire

//--- tb.sv
// self-checking bench for the port output latch block
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct {logic [7:0] addr; logic [31:0] exp;} note_t;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] avs_address_i = 8'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic [7:0] p0_out_o, p0_oe_o, p0_pullup_o;
   logic [6:0] p1_out_o, p1_oe_o, p1_pullup_o;
   logic reset_request_o;
   logic [14:0] pin;
   logic [14:0] ext_en = 15'h0;
   logic [14:0] ext = 15'h0;
   logic [31:0] seed = 32'h680F;
   logic [7:0] v, w;
   note_t notes[$];
   int n_mismatch = 0;
   int total_checks = 0;
   ///////////////////////////////////////////////////////////////////////////
   always #5 mclk_i = ~mclk_i;
   port_latches port_latches_inst (.mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .p0_pin_i(pin[7:0]), .p1_pin_i(pin[14:8]),
      .p0_out_o(p0_out_o), .p0_oe_o(p0_oe_o), .p0_pullup_o(p0_pullup_o), .p1_out_o(p1_out_o),
      .p1_oe_o(p1_oe_o), .p1_pullup_o(p1_pullup_o), .reset_request_o(reset_request_o));
   pin_board pin_board_inst (.mclk_i(mclk_i), .out_i({p1_out_o, p0_out_o}), .oe_i({p1_oe_o, p0_oe_o}),
      .pullup_i({p1_pullup_o, p0_pullup_o}), .ext_en_i(ext_en), .ext_i(ext), .pin_o(pin));
   ///////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] next_rand();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : next_rand
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // request held until waitrequest is sampled low, then one idle edge
   task automatic req(input logic rd, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
      avs_address_i <= a;
      avs_writedata_i <= {24'h0, d};
      avs_byteenable_i <= be;
      avs_read_i <= rd;
      avs_write_i <= ~rd;
      do
         @(posedge mclk_i);
      while (avs_waitrequest_o !== 1'b0);
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge mclk_i);
   endtask : req
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req(1'b0, a, d, 4'hF);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      notes.push_back('{a, {24'h0, e}});
      req(1'b1, a, 8'h00, 4'hF);
   endtask : rd
   // pin outputs lag the latch by one edge; three edges leave margin
   task automatic settle();
      repeat (3) @(posedge mclk_i);
   endtask : settle
   task automatic pins(input logic [7:0] o0, e0, u0, input logic [6:0] o1, e1, u1);
      chk("port0 out oe pullup", {8'h0, o0, e0, u0}, {8'h0, p0_out_o, p0_oe_o, p0_pullup_o});
      chk("port1 out oe pullup", {11'h0, o1, e1, u1}, {11'h0, p1_out_o, p1_oe_o, p1_pullup_o});
   endtask : pins
   task automatic test_done();
      if (n_mismatch == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done
   ///////////////////////////////////////////////////////////////////////////
   // monitor: every completed read is matched against the oldest note
   always @(posedge mclk_i)
      if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0)
      begin
         if (notes.size() == 0)
            chk("unexpected read", 32'h0, 32'h1);
         else
            chk($sformatf("readdata at %h", notes[0].addr), notes[0].exp, avs_readdata_o);
         if (notes.size() != 0)
            void'(notes.pop_front());
      end
   // watchdog: the whole sequence needs well under a thousand cycles
   initial
   begin
      repeat (4000) @(posedge mclk_i);
      n_mismatch++;
      test_done();
   end
   ///////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      rd(port_pkg::P0_LATCH_ADDR, 8'hFF);
      rd(port_pkg::P1_LATCH_ADDR, 8'h7F);
      pins(8'hFF, 8'h00, 8'hFF, 7'h7F, 7'h00, 7'h7F);
      chk("reset request", 32'h0, {31'h0, reset_request_o});
      // random latch values; shared pin stays pulled high, reserved bit set
      for (int i = 0; i < 4; i++)
      begin
         v = next_rand();
         w = next_rand() | 8'hC0;
         wr(port_pkg::P0_LATCH_ADDR, v);
         wr(port_pkg::P1_LATCH_ADDR, w);
         rd(port_pkg::P0_LATCH_ADDR, v);
         rd(port_pkg::P1_LATCH_ADDR, w & 8'h7F);
         settle();
         pins(v, 8'h00, v, w[6:0], 7'h00, w[6:0]);
         ext_en <= 15'h7FFF;
         ext <= {1'b1, ~w[5:0], ~v};
         settle();
         rd(port_pkg::P0_READBACK_ADDR, ~v);
         rd(port_pkg::P1_READBACK_ADDR, {2'b01, ~w[5:0]});
         rd(port_pkg::P0_LATCH_ADDR, v);
         ext_en <= 15'h0;
      end
      wr(port_pkg::P0_DIR_ADDR, 8'hFF);
      wr(port_pkg::P1_DIR_ADDR, 8'h3F);
      settle();
      pins(v, 8'hFF, 8'h00, w[6:0], 7'h3F, {w[6], 6'h0});
      rd(port_pkg::P0_READBACK_ADDR, v);
      rd(port_pkg::P1_READBACK_ADDR, w & 8'h7F);
      wr(port_pkg::P0_DIR_ADDR, 8'h00);
      rd(port_pkg::P0_LATCH_ADDR, v);
      rd(port_pkg::P1_LATCH_ADDR, w & 8'h7F);
      // refused: read-only place, missing lane, unmapped address
      wr(port_pkg::P0_READBACK_ADDR, 8'h00);
      req(1'b0, port_pkg::P0_LATCH_ADDR, 8'h00, 4'hE);
      wr(8'h1C, 8'h55);
      rd(8'h1C, 8'h00);
      rd(port_pkg::P0_LATCH_ADDR, v);
      // drive the shared pin low through latch and direction
      wr(port_pkg::P1_LATCH_ADDR, 8'h3F);
      wr(port_pkg::P1_DIR_ADDR, 8'h40);
      settle();
      chk("reset request", 32'h1, {31'h0, reset_request_o});
      wr(port_pkg::RST_CTRL_ADDR, 8'h01);
      settle();
      chk("reset request", 32'h0, {31'h0, reset_request_o});
      wr(port_pkg::RST_CTRL_ADDR, 8'h00);
      settle();
      chk("reset request", 32'h1, {31'h0, reset_request_o});
      // second reset in mid-run reloads everything
      rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      rd(port_pkg::P0_LATCH_ADDR, 8'hFF);
      rd(port_pkg::P1_LATCH_ADDR, 8'h7F);
      settle();
      chk("reset request", 32'h0, {31'h0, reset_request_o});
      test_done();
   end
endmodule : tb
`default_nettype wire
